/* hw/vcs_pkg.sv */
// Purpose: Shared constants and types of the valve command shaper
// Assumes: Commands are signed 16-bit, 16'h4000 is 100 %
// Notes:   Currents are in mA; ramp times are in ms
package vcs_pkg;

    // Operating configuration codes
    typedef enum logic [1:0] {
        BIPOLAR_ANALOG_CONFIG = 2'b00,
        DUAL_UNIPOLAR_CONFIG  = 2'b01,
        PRESET_DIGITAL_CONFIG = 2'b10
    } vcs_cfg_t;

    localparam logic [15:0] FULL_SCALE  = 16'h4000;
    localparam int          FULL_SHIFT  = 14;
    localparam int          FRAC_BITS   = 8;
    localparam logic [23:0] FULL_Q      = 24'h40_0000;
    localparam logic [15:0] CUR_MAX_MA  = 16'h0a28;
    localparam int          CURVE_PTS   = 10;
    localparam int          PRESETS     = 8;

    // Tick of the ramp generator
    localparam int MS_TIME_NS    = 32'h000f_4240;
    localparam int CLK_PERIOD_NS = 32'h0000_000a;
    localparam int TICK_DEFAULT  = MS_TIME_NS / CLK_PERIOD_NS;

    // Quadrant index of the ramp times
    localparam int Q_UP_POS = 0;
    localparam int Q_DN_POS = 1;
    localparam int Q_UP_NEG = 2;
    localparam int Q_DN_NEG = 3;

    // Bit positions in the pin synchroniser
    localparam int SY_EN   = 0;
    localparam int SY_S0   = 1;
    localparam int SY_S2   = 3;
    localparam int SY_DP   = 4;
    localparam int SY_DN   = 5;
    localparam int SY_FAST = 6;
    localparam int SY_FLT  = 7;
    localparam int SY_W    = 8;

endpackage : vcs_pkg

/* hw/vcs_valve_command_shaper.sv */
// Purpose: Command path of a proportional valve amplifier: enable and
//          error handling, preset select, ramps, output shaping
// Assumes: Analogue commands and parameters come from same-clock logic;
//          digital pins are asynchronous
// Notes:   Current targets feed the PWM current loop outside this block
`timescale 1ns/1ns
`default_nettype none

module vcs_valve_command_shaper
    import vcs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_DEFAULT
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rstn_i,
    input  wire vcs_cfg_t                config_mode_i,
    input  wire logic                    enable_i,
    input  wire logic                    fault_i,
    input  wire logic                    preset_select_bit0_i,
    input  wire logic                    preset_select_bit1_i,
    input  wire logic                    preset_select_bit2_i,
    input  wire logic                    dir_pos_i,
    input  wire logic                    dir_neg_i,
    input  wire logic                    speed_fast_i,
    input  wire logic [15:0]             analog_cmd_a_i,
    input  wire logic [15:0]             analog_cmd_b_i,
    input  wire logic [15:0]             rapid_speed_i,
    input  wire logic [15:0]             slow_speed_i,
    input  wire logic [7:0][15:0]        preset_value_i,
    input  wire logic [7:0][15:0]        preset_ramp_ms_i,
    input  wire logic                    ramp_selection_mode_i,
    input  wire logic [3:0][15:0]        ramp_time_ms_i,
    input  wire logic [15:0]             trigger_i,
    input  wire logic [15:0]             min_current_i,
    input  wire logic [15:0]             max_current_i,
    input  wire logic                    curve_linearize_switch_i,
    input  wire logic [9:0][15:0]        curve_points_side_a_x_i,
    input  wire logic [9:0][15:0]        curve_points_side_a_y_i,
    input  wire logic [9:0][15:0]        curve_points_side_b_x_i,
    input  wire logic [9:0][15:0]        curve_points_side_b_y_i,
    output logic                         ready_o,
    output logic                         stage_active_o,
    output logic [15:0]                  internal_cmd_a_o,
    output logic [15:0]                  current_target_a_o,
    output logic [15:0]                  current_target_b_o
);

    typedef struct packed {
        logic [SY_W-1:0]  sync1;
        logic [SY_W-1:0]  sync2;
        logic [31:0]      tick_cnt;
        logic             tick;
        logic             err;
        logic             active;
        logic [2:0]       addr;
        logic [1:0][23:0] tgt;
        logic [1:0][23:0] cmd;
        logic [1:0][15:0] cur;
    } vcs_state_t;

    vcs_state_t s;
    vcs_state_t next_s;
    logic       rst_meta;
    logic       rst_sync;

    ////////////////////////////////////////////////////////////////////
    // Piecewise-linear user characteristic
    function automatic logic [15:0] vcs_curve(
        input logic [15:0]      m,
        input logic [9:0][15:0] xs,
        input logic [9:0][15:0] ys);
        int     seg;
        longint dx;
        longint dy;
        longint r;
        seg = 0;
        for (int i = 1; i < CURVE_PTS; i++) begin
            if (m >= xs[i]) begin
                seg = i;
            end
        end
        if (m <= xs[0]) begin
            r = longint'(ys[0]);
        end else if (seg == CURVE_PTS - 1) begin
            r = longint'(ys[CURVE_PTS-1]);
        end else begin
            dx = longint'(xs[seg+1]) - longint'(xs[seg]);
            dy = longint'(ys[seg+1]) - longint'(ys[seg]);
            r  = longint'(ys[seg]);
            if (dx > 0) begin
                r = r + (dy * (longint'(m) - longint'(xs[seg]))) / dx;
            end
        end
        return r[15:0];
    endfunction : vcs_curve

    // Trigger, curve, min/max scaling and current cap
    function automatic logic [15:0] vcs_shape(
        input logic [23:0]      c,
        input logic             lin,
        input logic [9:0][15:0] xa,
        input logic [9:0][15:0] ya,
        input logic [9:0][15:0] xb,
        input logic [9:0][15:0] yb,
        input logic [15:0]      trig,
        input logic [15:0]      mn,
        input logic [15:0]      mx);
        logic        neg;
        logic [15:0] mag;
        logic [15:0] top;
        logic [15:0] amp;
        logic [31:0] prod;
        neg = c[23];
        mag = neg ? 16'(-c[23:FRAC_BITS]) : c[23:FRAC_BITS];
        if (mag > FULL_SCALE) begin
            mag = FULL_SCALE;
        end
        top = (mx > CUR_MAX_MA) ? CUR_MAX_MA : mx;
        if (mag <= trig) begin
            amp = 16'h0000;
        end else begin
            if (lin) begin
                mag = neg ? vcs_curve(mag, xb, yb)
                          : vcs_curve(mag, xa, ya);
            end
            if (mag > FULL_SCALE) begin
                mag = FULL_SCALE;
            end
            // Full command lands exactly on the maximum
            prod = (top > mn) ? (top - mn) * mag : 32'h0000_0000;
            amp  = mn + prod[FULL_SHIFT+15:FULL_SHIFT];
            if (amp > CUR_MAX_MA) begin
                amp = CUR_MAX_MA;
            end
        end
        return neg ? 16'(-amp) : amp;
    endfunction : vcs_shape

    // One ramp step toward the target; t = {dn_neg,up_neg,dn_pos,up_pos}
    function automatic logic [23:0] vcs_ramp(
        input logic [23:0]      cur,
        input logic [23:0]      tgt,
        input logic [3:0][15:0] t);
        logic signed [24:0] c;
        logic signed [24:0] g;
        logic signed [24:0] n;
        logic               pos;
        logic               away;
        logic [15:0]        tm;
        logic [23:0]        inc;
        c    = $signed({cur[23], cur});
        g    = $signed({tgt[23], tgt});
        pos  = (c > 0) || (c == 0 && g > 0);
        away = pos ? (g > c) : (g < c);
        tm   = t[{~pos, ~away}];
        // Zero time means follow the step at once
        inc  = (tm == 16'h0000) ? FULL_Q : FULL_Q / {8'h00, tm};
        if (g > c) begin
            n = c + $signed({1'b0, inc});
            if (n > g) begin
                n = g;
            end
        end else begin
            n = c - $signed({1'b0, inc});
            if (n < g) begin
                n = g;
            end
        end
        // Pause at zero so the other quadrant's time applies next
        if ((c > 0 && n < 0) || (c < 0 && n > 0)) begin
            n = 25'sd0;
        end
        return n[23:0];
    endfunction : vcs_ramp

    ////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic                en;
        logic                flt;
        logic [15:0]         spd;
        logic [1:0][23:0]    ref_q;
        logic [1:0][3:0][15:0] tq;
        logic [15:0]         pr;
        next_s       = s;
        next_s.sync1 = {fault_i, speed_fast_i, dir_neg_i, dir_pos_i,
                        preset_select_bit2_i, preset_select_bit1_i,
                        preset_select_bit0_i, enable_i};
        next_s.sync2 = s.sync1;
        en  = s.sync2[SY_EN];
        flt = s.sync2[SY_FLT];

        next_s.tick     = (s.tick_cnt == 32'(TICK_CYCLES - 1));
        next_s.tick_cnt = next_s.tick ? 32'h0000_0000 : s.tick_cnt + 1;

        // A fault in the clearing cycle still latches
        next_s.err    = flt | (s.err & en);
        next_s.active = en & ~next_s.err;
        next_s.addr   = s.sync2[SY_S2:SY_S0];

        spd   = s.sync2[SY_FAST] ? rapid_speed_i : slow_speed_i;
        ref_q = '0;
        tq[0] = ramp_time_ms_i;
        tq[1] = '0;
        pr    = preset_ramp_ms_i[s.addr];
        unique case (config_mode_i)
            BIPOLAR_ANALOG_CONFIG: begin
                // One direction input alone overrides the analogue command
                if (s.sync2[SY_DP] && !s.sync2[SY_DN]) begin
                    ref_q[0] = {spd, 8'h00};
                end else if (s.sync2[SY_DN] && !s.sync2[SY_DP]) begin
                    ref_q[0] = {16'(-spd), 8'h00};
                end else begin
                    ref_q[0] = {analog_cmd_a_i, 8'h00};
                end
            end
            DUAL_UNIPOLAR_CONFIG: begin
                ref_q[0] = analog_cmd_a_i[15] ? '0 : {analog_cmd_a_i, 8'h00};
                ref_q[1] = analog_cmd_b_i[15] ? '0 : {analog_cmd_b_i, 8'h00};
                tq[0] = {ramp_time_ms_i[Q_DN_POS], ramp_time_ms_i[Q_UP_POS],
                         ramp_time_ms_i[Q_DN_POS],
                         ramp_time_ms_i[Q_UP_POS]};
                tq[1] = {ramp_time_ms_i[Q_DN_NEG], ramp_time_ms_i[Q_UP_NEG],
                         ramp_time_ms_i[Q_DN_NEG],
                         ramp_time_ms_i[Q_UP_NEG]};
            end
            PRESET_DIGITAL_CONFIG: begin
                ref_q[0] = {preset_value_i[s.addr], 8'h00};
                if (ramp_selection_mode_i) begin
                    tq[0] = {pr, pr, pr, pr};
                end
            end
            default: begin
                ref_q = '0;
            end
        endcase

        for (int ch = 0; ch < 2; ch++) begin
            next_s.tgt[ch] = ref_q[ch];
            if (s.tick) begin
                next_s.cmd[ch] = vcs_ramp(s.cmd[ch], s.tgt[ch], tq[ch]);
            end
            if (!next_s.active) begin
                next_s.tgt[ch] = '0;
                next_s.cmd[ch] = '0;
            end
            next_s.cur[ch] = vcs_shape(next_s.cmd[ch],
                curve_linearize_switch_i,
                curve_points_side_a_x_i, curve_points_side_a_y_i,
                curve_points_side_b_x_i, curve_points_side_b_y_i,
                trigger_i, min_current_i, max_current_i);
            if (config_mode_i == DUAL_UNIPOLAR_CONFIG
                && next_s.cmd[ch][23]) begin
                next_s.cur[ch] = '0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign ready_o            = s.active;
    assign stage_active_o     = s.active;
    assign internal_cmd_a_o   = s.cmd[0][23:FRAC_BITS];
    assign current_target_a_o = s.cur[0];
    assign current_target_b_o = s.cur[1];

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_ready_no_err: assert property (@(posedge sys_clk_i)
        disable iff (!rst_sync)
        ready_o |-> !s.err && $past(s.sync2[SY_EN])
            && !$past(s.sync2[SY_FLT]))
        else $error("Ready while an error is latched");

    a_err_clear: assert property (@(posedge sys_clk_i)
        disable iff (!rst_sync)
        !s.sync2[SY_EN] && !s.sync2[SY_FLT] |=> !s.err)
        else $error("Error not cleared by enable low");

    a_err_sticky: assert property (@(posedge sys_clk_i)
        disable iff (!rst_sync)
        s.err && s.sync2[SY_EN] |=> s.err)
        else $error("Error dropped while enabled");

    a_stage_on: assert property (@(posedge sys_clk_i)
        disable iff (!rst_sync)
        s.sync2[SY_EN] && !s.sync2[SY_FLT] && !s.err |=> stage_active_o)
        else $error("Stage not activated by enable");

    a_force_zero: assert property (@(posedge sys_clk_i)
        disable iff (!rst_sync) !s.active |-> s.cmd == '0 && s.cur == '0)
        else $error("Output not forced to zero");

    a_preset_addr: assert property (@(posedge sys_clk_i)
        disable iff (!rst_sync)
        config_mode_i == PRESET_DIGITAL_CONFIG && s.active
        |=> !s.active || s.tgt[0][23:FRAC_BITS]
            == $past(preset_value_i[s.addr]))
        else $error("Preset target does not match address");

    a_ramp_on_tick: assert property (@(posedge sys_clk_i)
        disable iff (!rst_sync)
        s.active && !s.tick |=> !s.active || $stable(s.cmd))
        else $error("Ramp moved between ticks");

    a_deadband: assert property (@(posedge sys_clk_i)
        disable iff (!rst_sync)
        current_target_a_o != '0 |-> (s.cmd[0][23]
            ? 16'(-s.cmd[0][23:FRAC_BITS]) : s.cmd[0][23:FRAC_BITS])
            > $past(trigger_i))
        else $error("Output inside the insensitive band");

    a_dual_positive: assert property (@(posedge sys_clk_i)
        disable iff (!rst_sync)
        $past(config_mode_i) == DUAL_UNIPOLAR_CONFIG
        |-> !current_target_a_o[15] && !current_target_b_o[15])
        else $error("Negative output in dual config");

    a_current_cap: assert property (@(posedge sys_clk_i)
        disable iff (!rst_sync)
        (current_target_a_o[15] ? 16'(-current_target_a_o)
            : current_target_a_o) <= CUR_MAX_MA)
        else $error("Current target above limit");

endmodule : vcs_valve_command_shaper

`default_nettype wire

/* verif/vcs_ctrl_model.sv */
// Purpose: Machine controller model driving enable, select and speed pins
// Assumes: Requests come from the bench just after a rising edge
// Notes:   Slow mode lets every pin change lag three extra clocks
`timescale 1ns/1ns
`default_nettype none

module vcs_ctrl_model (
    input  wire logic       sys_clk_i,
    input  wire logic       slow_i,
    input  wire logic [6:0] req_i,
    output logic            enable_o,
    output logic [2:0]      sel_o,
    output logic            dir_pos_o,
    output logic            dir_neg_o,
    output logic            fast_o
);
    logic [6:0] held;
    logic [1:0] lag;

    // Slow answer: hold old pin levels while the lag counts up
    always_ff @(posedge sys_clk_i) begin
        if (req_i != held && slow_i && lag != 2'h3) begin
            lag <= lag + 2'h1;
        end else begin
            held <= req_i;
            lag  <= 2'h0;
        end
    end

    // Plain level pins, always driven
    assign {fast_o, dir_neg_o, dir_pos_o, sel_o, enable_o} = held;
endmodule : vcs_ctrl_model
`default_nettype wire

/* verif/tb_valve_command_shaper.sv */
// Purpose: Self-checking bench of the valve command shaper
// Assumes: Ramp tick cut to 10 clocks, so ramp times count ticks
// Notes:   Driver notes expectations; a monitor compares at each look
`timescale 1ns/1ns
`default_nettype none

module tb_valve_command_shaper import vcs_pkg::*;;
    localparam int TICK = 10;
    typedef struct {int sel; int kind; logic [15:0] exp;} vcs_note_t;
    vcs_note_t        notes[$];
    event             chk_ev;
    int               err_count = 0;
    int               tests_run = 0;
    string            nm[5] = '{"cmd_a", "target_a", "target_b", "ready",
                                "active"};
    logic [31:0]      seed = 32'h0001_6945;
    logic             sys_clk = 1'b0;
    logic             rstn = 1'b0, fault = 1'b0, slow = 1'b0;
    logic             mode = 1'b0, lin = 1'b0;
    logic [6:0]       req = '0;
    vcs_cfg_t         cfg = PRESET_DIGITAL_CONFIG;
    logic [15:0]      cmd_a = '0, cmd_b = '0, rapid = '0, slow_spd = '0;
    logic [15:0]      trig = 16'h0200, mn = 16'h01f4, mx = 16'h07d0;
    logic [7:0][15:0] pv = '0, pr = '0;
    logic [3:0][15:0] rt = '0;
    logic [9:0][15:0] ax, ay, bx, by;
    wire              en, dp, dn, fast, rdy, act;
    wire  [2:0]       sel;
    wire  [15:0]      cmd_o, tga, tgb;

    initial forever #5 sys_clk = ~sys_clk;

    vcs_ctrl_model i_vcs_ctrl_model (
        .sys_clk_i(sys_clk), .slow_i(slow), .req_i(req), .enable_o(en),
        .sel_o(sel), .dir_pos_o(dp), .dir_neg_o(dn), .fast_o(fast));

    vcs_valve_command_shaper #(.TICK_CYCLES(TICK)) i_vcs_valve_command_shaper (
        .sys_clk_i(sys_clk), .rstn_i(rstn), .config_mode_i(cfg),
        .enable_i(en), .fault_i(fault), .preset_select_bit0_i(sel[0]),
        .preset_select_bit1_i(sel[1]), .preset_select_bit2_i(sel[2]),
        .dir_pos_i(dp), .dir_neg_i(dn), .speed_fast_i(fast),
        .analog_cmd_a_i(cmd_a), .analog_cmd_b_i(cmd_b),
        .rapid_speed_i(rapid), .slow_speed_i(slow_spd),
        .preset_value_i(pv), .preset_ramp_ms_i(pr),
        .ramp_selection_mode_i(mode), .ramp_time_ms_i(rt),
        .trigger_i(trig), .min_current_i(mn), .max_current_i(mx),
        .curve_linearize_switch_i(lin), .curve_points_side_a_x_i(ax),
        .curve_points_side_a_y_i(ay), .curve_points_side_b_x_i(bx),
        .curve_points_side_b_y_i(by), .ready_o(rdy), .stage_active_o(act),
        .internal_cmd_a_o(cmd_o), .current_target_a_o(tga),
        .current_target_b_o(tgb));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd_cmd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return 16'(int'(seed % 32'd32769) - 16384);
    endfunction : rnd_cmd

    // Flat curves make the expectation independent of interpolation
    function automatic logic [15:0] exp_cur(input logic [15:0] c,
                                            input logic cv);
        int m;
        int top;
        int o;
        bit neg;
        m   = int'($signed(c));
        neg = m < 0;
        top = (mx > CUR_MAX_MA) ? int'(CUR_MAX_MA) : int'(mx);
        if (neg) m = -m;
        if (m > 16384) m = 16384;
        if (m <= int'(trig)) return '0;
        if (cv) m = neg ? 4096 : 8192;
        o = int'(mn) + (((top - int'(mn)) * m) >>> 14);
        if (o > int'(CUR_MAX_MA)) o = int'(CUR_MAX_MA);
        return neg ? 16'(-o) : 16'(o);
    endfunction : exp_cur

    task automatic note(input int s, input int k, input logic [15:0] e);
        notes.push_back('{s, k, e});
    endtask : note

    task automatic look();
        @(negedge sys_clk);
        -> chk_ev;
    endtask : look

    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : ticks

    task automatic pins(input logic e, input logic [2:0] s, input logic p,
                        input logic n, input logic f);
        @(posedge sys_clk);
        req <= {f, n, p, s, e};
    endtask : pins

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    initial begin
        vcs_note_t   n;
        logic [15:0] v;
        logic        ok;
        forever begin
            @(chk_ev);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                case (n.sel)
                    0: v = cmd_o;
                    1: v = tga;
                    2: v = tgb;
                    3: v = {15'h0000, rdy};
                    default: v = {15'h0000, act};
                endcase
                // Kind 1: ramp still under way, strictly between 0 and exp
                ok = (n.kind == 0) ? (v === n.exp) :
                     ($signed(v) > 0 && $signed(v) < $signed(n.exp));
                tests_run++;
                if (ok !== 1'b1) begin
                    err_count++;
                    $display("unexpected %s: expected %h, seen %h",
                             nm[n.sel], n.exp, v);
                end
            end
        end
    end

    initial begin
        #100000;
        err_count++;
        $display("unexpected watchdog: expected end, seen hang");
        wrap_up();
    end

    initial begin
        for (int i = 0; i < 10; i++) begin
            ax[i] = 16'(16'h0400 * (i + 1));
            bx[i] = ax[i];
            ay[i] = 16'h2000;
            by[i] = 16'h1000;
        end
        pv = {16'h0000, rnd_cmd(), rnd_cmd(), rnd_cmd(), 16'hc000,
              16'h0201, 16'h0200, 16'h4000};
        mode = 1'b1;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        ticks(6);
        note(3, 0, '0);
        note(1, 0, '0);
        look();
        pins(1, 0, 0, 0, 0);
        ticks(12);
        note(3, 0, 16'h0001);
        note(4, 0, 16'h0001);
        look();
        for (int a = 0; a < 8; a++) begin
            pins(1, 3'(a), 0, 0, 0);
            ticks(6 * TICK);
            note(0, 0, pv[a]);
            note(1, 0, exp_cur(pv[a], 1'b0));
            note(2, 0, '0);
            look();
        end
        @(posedge sys_clk);
        lin <= 1'b1;
        for (int a = 2; a < 4; a++) begin
            pins(1, 3'(a), 0, 0, 0);
            ticks(6 * TICK);
            note(1, 0, exp_cur(pv[a], 1'b1));
            look();
        end
        @(posedge sys_clk);
        lin  <= 1'b0;
        mode <= 1'b0;
        rt   <= {16'h0000, 16'h0000, 16'h0000, 16'h000a};
        pins(1, 7, 0, 0, 0);
        ticks(6 * TICK);
        pins(1, 0, 0, 0, 0);
        ticks(5 * TICK);
        note(0, 1, 16'h4000);
        look();
        ticks(12 * TICK);
        note(0, 0, 16'h4000);
        look();
        pins(1, 7, 0, 0, 0);
        ticks(3 * TICK);
        note(0, 0, '0);
        look();
        // Shared times jump, so only the per-value time can ramp here
        @(posedge sys_clk);
        mode  <= 1'b1;
        rt    <= '0;
        pr[0] <= 16'h000a;
        pins(1, 0, 0, 0, 0);
        ticks(5 * TICK);
        note(0, 1, 16'h4000);
        look();
        @(posedge sys_clk);
        slow  <= 1'b1;
        fault <= 1'b1;
        ticks(8);
        note(3, 0, '0);
        note(0, 0, '0);
        note(1, 0, '0);
        look();
        @(posedge sys_clk);
        fault <= 1'b0;
        ticks(8);
        note(3, 0, '0);
        look();
        pins(0, 0, 0, 0, 0);
        ticks(12);
        pins(1, 0, 0, 0, 0);
        ticks(16);
        note(3, 0, 16'h0001);
        look();
        @(posedge sys_clk);
        cfg   <= DUAL_UNIPOLAR_CONFIG;
        cmd_a <= 16'hf000;
        cmd_b <= 16'h2000;
        ticks(4 * TICK);
        note(1, 0, '0);
        note(2, 0, exp_cur(16'h2000, 1'b0));
        look();
        @(posedge sys_clk);
        cfg      <= BIPOLAR_ANALOG_CONFIG;
        rapid    <= 16'h4000;
        slow_spd <= 16'h1000;
        mx       <= 16'h0bb8;
        pins(1, 0, 1, 0, 1);
        ticks(6 * TICK);
        note(0, 0, 16'h4000);
        note(1, 0, CUR_MAX_MA);
        look();
        pins(1, 0, 0, 1, 0);
        ticks(6 * TICK);
        note(0, 0, 16'hf000);
        note(1, 0, exp_cur(16'hf000, 1'b0));
        look();
        // Both direction pins high fall back to the analogue command
        @(posedge sys_clk);
        cmd_a <= 16'h1000;
        pins(1, 0, 1, 1, 1);
        ticks(6 * TICK);
        note(0, 0, 16'h1000);
        look();
        pins(0, 0, 0, 0, 0);
        ticks(12);
        note(0, 0, '0);
        note(1, 0, '0);
        note(3, 0, '0);
        look();
        ticks(2);
        wrap_up();
    end
endmodule : tb_valve_command_shaper
`default_nettype wire
